// ### spl_pkg.sv
/*
  constants, register selects, status bit positions and the stack
  error check shared by the stack pointer, limit and status block.
  assumes a 16-bit data space with byte addresses and word stacks.
*/
package spl_pkg;

  // ==========================================================
  // widths and reset values
  localparam int DATA_W = 16;
  localparam int PC_W = 23;
  localparam logic [15:0] SP_RESET = 16'h0800;
  localparam logic [15:0] LIMIT_RESET = 16'h0000;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [15:0] FRAME_RESET = 16'h0000;
  localparam logic [15:0] UNDERFLOW_BASE = 16'h0800;
  localparam logic [15:0] STACK_STEP = 16'h0002;
  localparam logic [16:0] LIMIT_SLACK = 17'h0_0002;

  // ==========================================================
  // register selects on the core register port
  localparam logic [1:0] SEL_SP = 2'h0;
  localparam logic [1:0] SEL_LIMIT = 2'h1;
  localparam logic [1:0] SEL_STATUS = 2'h2;
  localparam logic [1:0] SEL_FRAME = 2'h3;

  // ==========================================================
  // status word bit positions
  localparam int ST_RA = 4;
  localparam int ST_DC = 8;
  localparam int ST_DA = 9;
  localparam int ST_SAB = 10;
  localparam int ST_OAB = 11;
  localparam int ST_SB = 12;
  localparam int ST_SA = 13;
  localparam int ST_OB = 14;
  localparam int ST_OA = 15;
  localparam int ST_IPL_LO = 5;
  // bits software writes freely: low byte except the repeat flag, and half carry
  localparam logic [15:0] ST_WR_MASK = 16'h01EF;

  // ==========================================================
  // stack engine states
  typedef enum logic [0:0] {ST_IDLE, ST_PC_HIGH} spl_state_type;

  // stack error for one effective address; underflow is always checked
  function automatic logic spl_stack_err(input logic [15:0] ea, input logic wrap,
                                         input logic [15:0] limit, input logic en);
    logic over;
    over = ({1'b0, ea} > ({1'b0, limit} + LIMIT_SLACK));
    spl_stack_err = (ea < UNDERFLOW_BASE) | (en & (over | wrap));
  endfunction

endpackage

// ### spl_chk.sv
/*
  one lane of the stack error check: qualifies an effective address
  against the limit. assumes the caller registers the result.
*/
`timescale 1ns/10ps
module spl_chk (
  input wire logic valid_i,
  input wire logic [15:0] ea_i,
  input wire logic wrap_i,
  input wire logic [15:0] limit_i,
  input wire logic en_i,
  output logic err_o
);
  import spl_pkg::*;

  // ==========================================================
  // compare
  always_comb begin
    err_o = valid_i & spl_stack_err(ea_i, wrap_i, limit_i, en_i);
  end

endmodule // spl_chk

// ### spl_core.sv
/*
  stack pointer, frame pointer, stack limit and cpu status word of the
  core, with stack push/pop sequencing and stack error detection.
  assumes the execution unit holds requests one cycle, waits while
  BUSY_O is high, and drives all inputs from the same core clock.
*/
`timescale 1ns/10ps
module spl_core (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic REG_WR_I,
  input wire logic [1:0] REG_SEL_I,
  input wire logic [1:0] REG_BE_I,
  input wire logic [spl_pkg::DATA_W-1:0] REG_WDATA_I,
  input wire logic PUSH_I,
  input wire logic [spl_pkg::DATA_W-1:0] PUSH_DATA_I,
  input wire logic POP_I,
  input wire logic CALL_I,
  input wire logic EXC_I,
  input wire logic [spl_pkg::PC_W-1:0] PC_I,
  input wire logic LINK_I,
  input wire logic [spl_pkg::DATA_W-1:0] LINK_LIT_I,
  input wire logic UNLINK_I,
  input wire logic EA_VALID_I,
  input wire logic [spl_pkg::DATA_W-1:0] EA_I,
  input wire logic EA_WRAP_I,
  input wire logic ALU_WE_I,
  input wire logic [4:0] ALU_FLAGS_I,
  input wire logic IPL_WE_I,
  input wire logic [2:0] IPL_I,
  input wire logic DO_ACTIVE_I,
  input wire logic REPEAT_ACTIVE_I,
  input wire logic OVF_A_I,
  input wire logic OVF_B_I,
  input wire logic CLIP_A_I,
  input wire logic CLIP_B_I,
  output logic [spl_pkg::DATA_W-1:0] SP_O,
  output logic [spl_pkg::DATA_W-1:0] FP_O,
  output logic [spl_pkg::DATA_W-1:0] LIMIT_O,
  output logic [spl_pkg::DATA_W-1:0] STATUS_O,
  output logic CHK_EN_O,
  output logic BUSY_O,
  output logic STACK_WE_O,
  output logic STACK_RE_O,
  output logic [spl_pkg::DATA_W-1:0] STACK_ADDR_O,
  output logic [spl_pkg::DATA_W-1:0] STACK_WDATA_O,
  output logic STACK_TRAP_O
);
  import spl_pkg::*;

  // ==========================================================
  // state
  spl_state_type state_q, state_d;
  logic [15:0] sp_q, sp_d, fp_q, fp_d, limit_q, limit_d, status_q, status_d;
  logic chk_en_q, chk_en_d, busy_q, busy_d;
  logic we_q, we_d, re_q, re_d, trap_q, trap_d;
  logic [15:0] addr_q, addr_d, wdata_q, wdata_d;
  logic [7:0] pc_high_q, pc_high_d;
  logic exc_q, exc_d;
  logic op_valid, op_wrap, err_int, err_ext;
  logic [15:0] op_addr;
  logic [16:0] sum;
  logic wr_sp, wr_fp, wr_limit, wr_status, word_wr;
  logic [15:0] be_mask, sw_clr;

  // byte lanes of the register port
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nv,
                                        input logic [1:0] be);
    merge = {be[1] ? nv[15:8] : old[15:8], be[0] ? nv[7:0] : old[7:0]};
  endfunction

  always_comb begin
    word_wr = REG_WR_I & (REG_BE_I == 2'h3);
    wr_sp = REG_WR_I & (REG_SEL_I == SEL_SP);
    wr_fp = REG_WR_I & (REG_SEL_I == SEL_FRAME);
    wr_limit = REG_WR_I & (REG_SEL_I == SEL_LIMIT);
    wr_status = REG_WR_I & (REG_SEL_I == SEL_STATUS);
    be_mask = {{8{REG_BE_I[1]}}, {8{REG_BE_I[0]}}};
  end

  // ==========================================================
  // stack engine
  always_comb begin
    state_d = state_q;
    sp_d = sp_q;
    fp_d = fp_q;
    pc_high_d = pc_high_q;
    exc_d = exc_q;
    we_d = 1'b0;
    re_d = 1'b0;
    addr_d = addr_q;
    wdata_d = wdata_q;
    op_valid = 1'b0;
    op_addr = sp_q;
    sum = {1'b0, sp_q} + {1'b0, STACK_STEP};
    case (state_q)
      ST_IDLE: begin
        if (EXC_I | CALL_I) begin
          // low half of the counter goes first, high half next cycle
          op_valid = 1'b1;
          we_d = 1'b1;
          addr_d = sp_q;
          wdata_d = PC_I[15:0];
          pc_high_d = {1'b0, PC_I[22:16]};
          exc_d = EXC_I;
          sp_d = sum[15:0];
          state_d = ST_PC_HIGH;
        end else if (LINK_I) begin
          op_valid = 1'b1;
          we_d = 1'b1;
          addr_d = sp_q;
          wdata_d = fp_q;
          fp_d = sum[15:0];
          sum = {1'b0, sp_q} + {1'b0, STACK_STEP} + {1'b0, LINK_LIT_I};
          sp_d = sum[15:0];
        end else if (UNLINK_I) begin
          op_valid = 1'b1;
          sum = {1'b0, fp_q} - {1'b0, STACK_STEP};
          op_addr = sum[15:0];
          re_d = 1'b1;
          addr_d = sum[15:0];
          sp_d = sum[15:0];
        end else if (PUSH_I) begin
          op_valid = 1'b1;
          we_d = 1'b1;
          addr_d = sp_q;
          wdata_d = PUSH_DATA_I;
          sp_d = sum[15:0];
        end else if (POP_I) begin
          op_valid = 1'b1;
          sum = {1'b0, sp_q} - {1'b0, STACK_STEP};
          op_addr = sum[15:0];
          re_d = 1'b1;
          addr_d = sum[15:0];
          sp_d = sum[15:0];
        end
      end
      ST_PC_HIGH: begin
        op_valid = 1'b1;
        we_d = 1'b1;
        addr_d = sp_q;
        // calls zero-fill, exceptions carry the status low byte
        wdata_d = {exc_q ? status_q[7:0] : 8'h00, pc_high_q};
        sp_d = sum[15:0];
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    op_wrap = sum[16];
    // a software write of the pointer dominates the automatic update
    if (wr_sp) begin
      sp_d = merge(sp_q, REG_WDATA_I, REG_BE_I);
    end
    if (wr_fp) begin
      fp_d = merge(fp_q, REG_WDATA_I, REG_BE_I);
    end
    sp_d[0] = 1'b0;
    busy_d = (state_d == ST_PC_HIGH);
  end

  // ==========================================================
  // limit and error check
  always_comb begin
    limit_d = limit_q;
    chk_en_d = chk_en_q;
    if (wr_limit) begin
      limit_d = merge(limit_q, REG_WDATA_I, REG_BE_I);
      chk_en_d = chk_en_q | word_wr;
    end
    limit_d[0] = 1'b0;
    trap_d = err_int | err_ext;
  end

  // internal stack accesses and those formed by the execution unit
  spl_chk u_chk_int (
    .valid_i(op_valid),
    .ea_i(op_addr),
    .wrap_i(op_wrap),
    .limit_i(limit_q),
    .en_i(chk_en_q),
    .err_o(err_int)
  );

  spl_chk u_chk_ext (
    .valid_i(EA_VALID_I),
    .ea_i(EA_I),
    .wrap_i(EA_WRAP_I),
    .limit_i(limit_q),
    .en_i(chk_en_q),
    .err_o(err_ext)
  );

  // ==========================================================
  // status word
  always_comb begin
    status_d = status_q;
    sw_clr = 16'h0000;
    if (ALU_WE_I) begin
      status_d[3:0] = ALU_FLAGS_I[3:0];
      status_d[ST_DC] = ALU_FLAGS_I[4];
    end
    if (IPL_WE_I) begin
      status_d[ST_IPL_LO +: 3] = IPL_I;
    end
    if (wr_status) begin
      status_d = (status_d & ~(ST_WR_MASK & be_mask)) |
                 (REG_WDATA_I & ST_WR_MASK & be_mask);
      sw_clr = ~REG_WDATA_I & be_mask;
    end
    // loop and overflow bits follow hardware only
    status_d[ST_DA] = DO_ACTIVE_I;
    status_d[ST_RA] = REPEAT_ACTIVE_I;
    status_d[ST_OA] = OVF_A_I;
    status_d[ST_OB] = OVF_B_I;
    status_d[ST_OAB] = OVF_A_I | OVF_B_I;
    // a new clip in the clearing cycle survives the clear
    status_d[ST_SA] = CLIP_A_I | (status_q[ST_SA] & ~sw_clr[ST_SA] & ~sw_clr[ST_SAB]);
    status_d[ST_SB] = CLIP_B_I | (status_q[ST_SB] & ~sw_clr[ST_SB] & ~sw_clr[ST_SAB]);
    status_d[ST_SAB] = status_d[ST_SA] | status_d[ST_SB];
  end

  // ==========================================================
  // registers
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      state_q <= ST_IDLE;
      sp_q <= SP_RESET;
      fp_q <= FRAME_RESET;
      limit_q <= LIMIT_RESET;
      status_q <= STATUS_RESET;
      chk_en_q <= 1'b0;
      busy_q <= 1'b0;
      we_q <= 1'b0;
      re_q <= 1'b0;
      trap_q <= 1'b0;
      addr_q <= 16'h0000;
      wdata_q <= 16'h0000;
      pc_high_q <= 8'h00;
      exc_q <= 1'b0;
    end else begin
      state_q <= state_d;
      sp_q <= sp_d;
      fp_q <= fp_d;
      limit_q <= limit_d;
      status_q <= status_d;
      chk_en_q <= chk_en_d;
      busy_q <= busy_d;
      we_q <= we_d;
      re_q <= re_d;
      trap_q <= trap_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      pc_high_q <= pc_high_d;
      exc_q <= exc_d;
    end
  end

  always_comb begin
    SP_O = sp_q;
    FP_O = fp_q;
    LIMIT_O = limit_q;
    STATUS_O = status_q;
    CHK_EN_O = chk_en_q;
    BUSY_O = busy_q;
    STACK_WE_O = we_q;
    STACK_RE_O = re_q;
    STACK_ADDR_O = addr_q;
    STACK_WDATA_O = wdata_q;
    STACK_TRAP_O = trap_q;
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  logic idle_push;
  assign idle_push = (state_q == ST_IDLE) & PUSH_I & ~POP_I & ~CALL_I & ~EXC_I &
                     ~LINK_I & ~UNLINK_I & ~wr_sp;

  a_sp_word_aligned: assert property (SP_O[0] == 1'b0)
    else $error("stack pointer bit 0 set");
  a_sp_reset_value: assert property ($past(RST_I) |-> SP_O == SP_RESET)
    else $error("stack pointer reset value wrong");
  a_push_post_incr: assert property (idle_push |=> STACK_WE_O &&
      STACK_ADDR_O == $past(SP_O) && SP_O == $past(SP_O) + STACK_STEP)
    else $error("push did not write then increment");
  a_call_two_words: assert property ((state_q == ST_IDLE) && CALL_I && !EXC_I |=>
      STACK_WDATA_O == $past(PC_I[15:0]) ##1
      STACK_WE_O && STACK_WDATA_O == {8'h00, 1'b0, $past(PC_I[22:16], 2)})
    else $error("call push words wrong");
  a_exc_status_byte: assert property ((state_q == ST_IDLE) && EXC_I |=> ##1
      STACK_WDATA_O[15:8] == $past(STATUS_O[7:0]) && STACK_WDATA_O[6:0] == $past(PC_I[22:16], 2))
    else $error("exception push lacks status byte");
  a_limit_aligned: assert property (LIMIT_O[0] == 1'b0)
    else $error("limit bit 0 set");
  a_check_stays_on: assert property (CHK_EN_O |=> CHK_EN_O)
    else $error("overflow check turned off");
  a_byte_no_enable: assert property (!CHK_EN_O && !(wr_limit && word_wr) |=> !CHK_EN_O)
    else $error("check enabled without word write");
  a_underflow_trap: assert property (EA_VALID_I && EA_I < UNDERFLOW_BASE |=> STACK_TRAP_O)
    else $error("underflow not trapped");
  a_overflow_trap: assert property (CHK_EN_O && EA_VALID_I &&
      ({1'b0, EA_I} > {1'b0, LIMIT_O} + LIMIT_SLACK) |=> STACK_TRAP_O)
    else $error("overflow not trapped");
  a_limit_edge_ok: assert property (!op_valid && EA_VALID_I && !EA_WRAP_I &&
      EA_I == LIMIT_O + STACK_STEP && EA_I >= UNDERFLOW_BASE |=> !STACK_TRAP_O)
    else $error("push at limit plus two trapped");
  a_loop_bits_ro: assert property (!$past(RST_I) |->
      STATUS_O[ST_DA] == $past(DO_ACTIVE_I) && STATUS_O[ST_RA] == $past(REPEAT_ACTIVE_I))
    else $error("loop bits not hardware driven");
  a_sticky_holds: assert property ($past(STATUS_O[ST_SA]) && !$past(wr_status) &&
      !$past(RST_I) |-> STATUS_O[ST_SA])
    else $error("sticky bit dropped");
  a_sab_clears_both: assert property (wr_status && REG_BE_I[1] && !REG_WDATA_I[ST_SAB] &&
      !CLIP_A_I && !CLIP_B_I |=> !STATUS_O[ST_SA] && !STATUS_O[ST_SB])
    else $error("combined clear left a sticky bit");

  c_call_push: cover property ((state_q == ST_IDLE) && CALL_I ##2 STACK_WE_O);
  c_exc_push: cover property ((state_q == ST_IDLE) && EXC_I ##2 STACK_WE_O);
  c_overflow: cover property (CHK_EN_O && STACK_TRAP_O);
  c_pop: cover property (STACK_RE_O);

endmodule // spl_core

// ### spl_mem.sv
/*
  data memory model on the far side of the stack port: keeps stack
  writes and answers stack reads one cycle later.
  assumes strobes come from the same core clock.
*/
`timescale 1ns/10ps
module spl_mem (
  input wire logic clk_i,
  input wire logic we_i,
  input wire logic re_i,
  input wire logic [15:0] addr_i,
  input wire logic [15:0] wdata_i,
  output logic [15:0] rdata_o
);
  // ==========================================================
  // word storage
  logic [15:0] mem [0:32767];

  always @(posedge clk_i) begin
    if (we_i) begin
      mem[addr_i[15:1]] <= wdata_i;
    end
    // data is inverted every cycle without a read, so a stale word comes back every second cycle
    rdata_o <= re_i ? mem[addr_i[15:1]] : ~rdata_o;
  end
endmodule // spl_mem

// ### testbench.sv
/*
  self-checking bench for the stack pointer, limit and status block.
  assumes spl_pkg, spl_core and the spl_mem model are compiled first.
*/
`timescale 1ns/10ps
module testbench;
  import spl_pkg::*;
  // ==========================================================
  // stimulus and observed signals
  logic clk, rst, reg_wr, push, pop, call, exc, link, unlink, ea_v, ea_wrap;
  logic alu_we, ipl_we, do_act, rep_act, ovf_a, ovf_b, clip_a, clip_b;
  logic [1:0] sel, be;
  logic [15:0] wdata, pdata, lit, ea, sp, fp, lim, st, saddr, swdata, rdata;
  logic [22:0] pc;
  logic [4:0] flags;
  logic [2:0] ipl;
  logic chk_en, busy, swe, sre, trap;
  int err_total, n_compared;
  localparam logic [7:0] k_wr = 8'h01, k_push = 8'h02, k_pop = 8'h04, k_call = 8'h08;
  localparam logic [7:0] k_exc = 8'h10, k_link = 8'h20, k_unlink = 8'h40, k_ea = 8'h80;
  logic [15:0] ea_tab [3] = '{16'h2000, 16'h2002, 16'h1000};
  logic wrap_tab [3] = '{1'b0, 1'b0, 1'b1};
  logic trap_tab [3] = '{1'b0, 1'b1, 1'b1};

  spl_core dut (.CLK_I(clk), .RST_I(rst), .REG_WR_I(reg_wr), .REG_SEL_I(sel),
    .REG_BE_I(be), .REG_WDATA_I(wdata), .PUSH_I(push), .PUSH_DATA_I(pdata),
    .POP_I(pop), .CALL_I(call), .EXC_I(exc), .PC_I(pc), .LINK_I(link),
    .LINK_LIT_I(lit), .UNLINK_I(unlink), .EA_VALID_I(ea_v), .EA_I(ea),
    .EA_WRAP_I(ea_wrap), .ALU_WE_I(alu_we), .ALU_FLAGS_I(flags), .IPL_WE_I(ipl_we),
    .IPL_I(ipl), .DO_ACTIVE_I(do_act), .REPEAT_ACTIVE_I(rep_act), .OVF_A_I(ovf_a),
    .OVF_B_I(ovf_b), .CLIP_A_I(clip_a), .CLIP_B_I(clip_b), .SP_O(sp), .FP_O(fp),
    .LIMIT_O(lim), .STATUS_O(st), .CHK_EN_O(chk_en), .BUSY_O(busy),
    .STACK_WE_O(swe), .STACK_RE_O(sre), .STACK_ADDR_O(saddr),
    .STACK_WDATA_O(swdata), .STACK_TRAP_O(trap));

  spl_mem mem (.clk_i(clk), .we_i(swe), .re_i(sre), .addr_i(saddr),
    .wdata_i(swdata), .rdata_o(rdata));

  // ==========================================================
  // shared tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chkb(input logic got, input logic exp);
    chk({15'h0000, got}, {15'h0000, exp});
  endtask

  task automatic tick;
    @(posedge clk);
    #1;
  endtask

  // one request strobe for one cycle; results are visible on return
  task automatic go(input logic [7:0] k);
    tick;
    {ea_v, unlink, link, exc, call, pop, push, reg_wr} = k;
    tick;
    {ea_v, unlink, link, exc, call, pop, push, reg_wr} = 8'h00;
  endtask

  task automatic wr(input logic [1:0] s, input logic [1:0] b, input logic [15:0] d);
    sel = s;
    be = b;
    wdata = d;
    go(k_wr);
  endtask

  task automatic wrap_up;
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ==========================================================
  // clock and watchdog
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    repeat (3000) @(posedge clk);
    err_total++;
    wrap_up;
  end

  // ==========================================================
  // test sequence
  initial begin
    rst = 1'b1;
    {reg_wr, push, pop, call, exc, link, unlink, ea_v, ea_wrap} = 9'h000;
    {alu_we, ipl_we, do_act, rep_act, ovf_a, ovf_b, clip_a, clip_b} = 8'h00;
    sel = 2'h0;
    be = 2'h3;
    wdata = 16'h0000;
    pdata = 16'h0000;
    lit = 16'h0000;
    ea = 16'h0000;
    pc = 23'h00_0000;
    flags = 5'h00;
    ipl = 3'h0;
    err_total = 0;
    n_compared = 0;
    repeat (4) tick;
    rst = 1'b0;
    chk(sp, 16'h0800);
    chk(lim, 16'h0000);
    chkb(chk_en, 1'b0);
    // underflow traps with the limit check still off
    ea = 16'h07FE;
    go(k_ea);
    chkb(trap, 1'b1);
    tick;
    chkb(trap, 1'b0);
    pdata = 16'h5A5A;
    go(k_push);
    chkb(swe, 1'b1);
    chk(saddr, 16'h0800);
    chk(swdata, 16'h5A5A);
    chkb(trap, 1'b0);
    pdata = 16'h3636;
    go(k_push);
    chk(sp, 16'h0804);
    go(k_pop);
    chkb(sre, 1'b1);
    chk(saddr, 16'h0802);
    chk(sp, 16'h0802);
    tick;
    chk(rdata, 16'h3636);
    chkb(sre, 1'b0);
    wr(SEL_SP, 2'h3, 16'h1235);
    chk(sp, 16'h1234);
    pc = 23'h12_3456;
    go(k_call);
    chk(saddr, 16'h1234);
    chk(swdata, 16'h3456);
    chkb(busy, 1'b1);
    tick;
    chk(saddr, 16'h1236);
    chk(swdata, 16'h0012);
    chk(sp, 16'h1238);
    chkb(busy, 1'b0);
    ipl = 3'h5;
    flags = 5'h1A;
    ipl_we = 1'b1;
    alu_we = 1'b1;
    tick;
    ipl_we = 1'b0;
    alu_we = 1'b0;
    chk(st, 16'h01AA);
    pc = 23'h7F_0000;
    go(k_exc);
    chk(swdata, 16'h0000);
    tick;
    chk(saddr, 16'h123A);
    chk(swdata, 16'hAA7F);
    wr(SEL_FRAME, 2'h3, 16'h0A0A);
    lit = 16'h0010;
    go(k_link);
    chk(swdata, 16'h0A0A);
    chk(fp, 16'h123E);
    chk(sp, 16'h124E);
    go(k_unlink);
    chk(sp, 16'h123C);
    tick;
    chk(rdata, 16'h0A0A);
    wr(SEL_STATUS, 2'h3, 16'hFFFF);
    chk(st, 16'h01EF);
    do_act = 1'b1;
    rep_act = 1'b1;
    ovf_a = 1'b1;
    clip_b = 1'b1;
    tick;
    clip_b = 1'b0;
    tick;
    chk(st, 16'h9FFF);
    wr(SEL_STATUS, 2'h3, 16'h0000);
    chk(st, 16'h8A10);
    clip_a = 1'b1;
    tick;
    clip_a = 1'b0;
    tick;
    tick;
    chk(st, 16'hAE10);
    wr(SEL_STATUS, 2'h3, 16'hFBFF);
    chk(st, 16'h8BFF);
    ovf_a = 1'b0;
    ovf_b = 1'b1;
    tick;
    tick;
    chk(st, 16'h4BFF);
    wr(SEL_LIMIT, 2'h1, 16'h12FF);
    chk(lim, 16'h00FE);
    chkb(chk_en, 1'b0);
    wr(SEL_LIMIT, 2'h3, 16'h1FFF);
    chk(lim, 16'h1FFE);
    chkb(chk_en, 1'b1);
    wr(SEL_LIMIT, 2'h2, 16'h2000);
    chk(lim, 16'h20FE);
    wr(SEL_LIMIT, 2'h3, 16'h1FFE);
    wr(SEL_SP, 2'h3, 16'h2000);
    go(k_push);
    chkb(trap, 1'b0);
    go(k_push);
    chkb(trap, 1'b1);
    tick;
    chkb(trap, 1'b0);
    for (int i = 0; i < 3; i++) begin
      ea = ea_tab[i];
      ea_wrap = wrap_tab[i];
      go(k_ea);
      chkb(trap, trap_tab[i]);
    end
    ea_wrap = 1'b0;
    rst = 1'b1;
    tick;
    rst = 1'b0;
    chk(sp, 16'h0800);
    chkb(chk_en, 1'b0);
    wrap_up;
  end
endmodule // testbench
